// File: verilog/flash_status_pkg.sv
// Package with constants and types for the flash write-status reporting block
package flash_status_pkg;

  // Timing figures in their own units and cycle counts at 50 MHz
  localparam int CLK_MHZ = 50;
  localparam int PROT_PROG_NS = 1000;
  localparam int PROT_ERASE_US = 150;
  localparam int PROT_PROG_CYC = PROT_PROG_NS * CLK_MHZ / 1000;
  localparam int PROT_ERASE_CYC = PROT_ERASE_US * CLK_MHZ;
  localparam int READY_BUSY_NS = 20000;
  localparam int READY_IDLE_NS = 500;
  localparam int READY_BUSY_CYC = READY_BUSY_NS * CLK_MHZ / 1000;
  localparam int READY_IDLE_CYC = READY_IDLE_NS * CLK_MHZ / 1000;
  localparam int RH_NS = 200;
  localparam int RH_CYC = (RH_NS * CLK_MHZ + 999) / 1000;

  // Status bit positions within a read word
  localparam int POLARITY_POS = 7;
  localparam int TOGGLE_POS = 6;
  localparam int TIMEOUT_POS = 5;

  // Command kinds after the decoder has framed the write sequence
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_PROGRAM = 3'h1,
    CMD_CHIP_ERASE = 3'h2,
    CMD_SECTOR_ERASE = 3'h3,
    CMD_SUSPEND = 3'h4,
    CMD_RESUME = 3'h5,
    CMD_RESET = 3'h6
  } cmd_e;

  // Operation states, one-hot
  typedef enum logic [6:0] {
    ST_READ = 7'b000_0001,
    ST_PROG = 7'b000_0010,
    ST_ERASE = 7'b000_0100,
    ST_SUSP = 7'b000_1000,
    ST_SUSP_PROG = 7'b001_0000,
    ST_FAIL = 7'b010_0000,
    ST_HWRST = 7'b100_0000
  } op_e;

  // One framed command: kind, target word and protection of its sector
  typedef struct packed {
    cmd_e kind;
    logic protect;
    logic [15:0] data;
  } cmd_s;

  // Completion report from the array engine
  typedef struct packed {
    logic done;
    logic limit;
  } engine_s;

endpackage

// File: verilog/flash_write_status.sv
// Write-operation status reporting: complement polling, toggle, timeout and ready/busy
`timescale 1ns/1ps
module flash_write_status
  import flash_status_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int PROT_ERASE_CYCLES = PROT_ERASE_CYC,
  parameter int READY_BUSY_CYCLES = READY_BUSY_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Framed command, strobed on the rising edge of the final write pulse
  input wire logic cmd_valid,
  input wire cmd_s cmd,
  // Array engine completion
  input wire engine_s engine,
  // Read strobe (output enable edge or address-valid edge) and array data
  input wire logic read_strobe,
  input wire logic poll_bank_hit,
  input wire logic [WIDTH-1:0] array_data,
  // Hardware reset pin, active low
  input wire logic hw_reset_n,
  // Read data and status
  output logic [WIDTH-1:0] read_data,
  output logic busy,
  output logic engine_start,
  output logic ready_busy_n_oe,
  output logic ready_busy_n_out,
  output logic read_allowed
);

  localparam int CW = 24;

  // Refuse sizes the read word or the 24-bit counters cannot hold
  if (WIDTH < 8) begin : g_width_check
    $error("WIDTH must be at least 8");
  end
  if (PROT_ERASE_CYCLES < 1 || PROT_ERASE_CYCLES >= (1 << CW)) begin : g_guard_check
    $error("PROT_ERASE_CYCLES does not fit the guard counter");
  end
  if (READY_BUSY_CYCLES < 1 || READY_BUSY_CYCLES >= (1 << CW)) begin : g_recovery_check
    $error("READY_BUSY_CYCLES does not fit the recovery counter");
  end

  op_e state_q;
  logic [WIDTH-1:0] last_data_q;
  logic [CW-1:0] guard_q;
  logic guard_prog_q;
  logic guard_erase_q;
  logic toggle_q;
  logic settle_q;
  logic hw_busy_q;
  logic [CW-1:0] rst_cnt_q;
  logic [CW-1:0] rh_cnt_q;
  logic hw_reset_prev_q;
  logic busy_d;
  logic accept_new;

  // New program or erase taken only while not busy; suspend skips this gate but is taken only during an erase
  assign accept_new = cmd_valid && !busy_d && !hw_busy_q;

  // Main operation state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_READ;
    end else if (!hw_reset_n) begin
      state_q <= ST_HWRST;
    end else begin
      case (state_q)
        ST_READ: begin
          if (accept_new && !cmd.protect && cmd.kind == CMD_PROGRAM) begin
            state_q <= ST_PROG;
          end else if (accept_new && !cmd.protect &&
                       (cmd.kind == CMD_CHIP_ERASE || cmd.kind == CMD_SECTOR_ERASE)) begin
            state_q <= ST_ERASE;
          end
        end
        ST_PROG, ST_SUSP_PROG: begin
          if (engine.limit) begin
            state_q <= ST_FAIL;
          end else if (engine.done) begin
            state_q <= (state_q == ST_SUSP_PROG) ? ST_SUSP : ST_READ;
          end
        end
        ST_ERASE: begin
          if (cmd_valid && cmd.kind == CMD_SUSPEND) begin
            state_q <= ST_SUSP;
          end else if (engine.limit) begin
            state_q <= ST_FAIL;
          end else if (engine.done) begin
            state_q <= ST_READ;
          end
        end
        ST_SUSP: begin
          if (cmd_valid && cmd.kind == CMD_RESUME) begin
            state_q <= ST_ERASE;
          end else if (cmd_valid && cmd.kind == CMD_PROGRAM && !cmd.protect) begin
            state_q <= ST_SUSP_PROG;
          end
        end
        ST_FAIL: begin
          if (cmd_valid && cmd.kind == CMD_RESET) begin
            state_q <= ST_READ;
          end
        end
        ST_HWRST: begin
          if (!hw_busy_q) begin
            state_q <= ST_READ;
          end
        end
        default: state_q <= ST_READ;
      endcase
    end
  end

  // Last written word, reference for the inverted polling bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_data_q <= '0;
    end else if (cmd_valid && cmd.kind == CMD_PROGRAM &&
                 ((state_q == ST_READ && accept_new) || state_q == ST_SUSP)) begin
      last_data_q <= cmd.data;
    end
  end

  // Protected-sector guard windows; sector contents are never touched
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      guard_q <= '0;
      guard_prog_q <= 1'b0;
      guard_erase_q <= 1'b0;
    end else if (accept_new && cmd.protect && state_q == ST_READ &&
                 cmd.kind == CMD_PROGRAM) begin
      guard_q <= CW'(PROT_PROG_CYC);
      guard_prog_q <= 1'b1;
      guard_erase_q <= 1'b0;
    end else if (accept_new && cmd.protect && state_q == ST_READ &&
                 (cmd.kind == CMD_CHIP_ERASE || cmd.kind == CMD_SECTOR_ERASE)) begin
      guard_q <= CW'(PROT_ERASE_CYCLES);
      guard_prog_q <= 1'b0;
      guard_erase_q <= 1'b1;
    end else if (guard_q > 1) begin
      guard_q <= guard_q - 1'b1;
    end else begin
      guard_q <= '0;
      guard_prog_q <= 1'b0;
      guard_erase_q <= 1'b0;
    end
  end

  // Toggle bit flips on every status read while an algorithm runs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      toggle_q <= 1'b0;
    end else if (read_strobe && (state_q == ST_PROG || state_q == ST_ERASE ||
                                 state_q == ST_SUSP_PROG || guard_q != '0)) begin
      toggle_q <= ~toggle_q;
    end
  end

  // One read after a program completes carries only the true polarity bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      settle_q <= 1'b0;
    end else if ((state_q == ST_PROG || state_q == ST_SUSP_PROG) && engine.done) begin
      settle_q <= 1'b1;
    end else if (read_strobe) begin
      settle_q <= 1'b0;
    end
  end

  // Read word assembly
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      read_data <= '0;
    end else if (read_strobe) begin
      read_data <= array_data;
      if (poll_bank_hit) begin
        if (state_q == ST_PROG || state_q == ST_SUSP_PROG || guard_prog_q) begin
          read_data <= array_data;
          read_data[POLARITY_POS] <= ~last_data_q[POLARITY_POS];
          read_data[TOGGLE_POS] <= ~toggle_q;
          read_data[TIMEOUT_POS] <= 1'b0;
        end else if (state_q == ST_ERASE || state_q == ST_SUSP) begin
          read_data[POLARITY_POS] <= 1'b0;
          read_data[TOGGLE_POS] <= (state_q == ST_ERASE) ? ~toggle_q : toggle_q;
          read_data[TIMEOUT_POS] <= 1'b0;
        end else if (guard_erase_q) begin
          read_data[TOGGLE_POS] <= ~toggle_q;
        end else if (state_q == ST_FAIL) begin
          read_data[POLARITY_POS] <= ~last_data_q[POLARITY_POS];
          read_data[TIMEOUT_POS] <= 1'b1;
        end else if (settle_q) begin
          read_data <= ~array_data;
          read_data[POLARITY_POS] <= array_data[POLARITY_POS];
        end
      end
    end
  end

  // Internal busy flag: set on acceptance, cleared on completion or suspend
  always_comb begin
    busy_d = (state_q == ST_PROG) || (state_q == ST_ERASE) ||
             (state_q == ST_SUSP_PROG);
  end

  // Hardware reset recovery timing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hw_busy_q <= 1'b0;
      rst_cnt_q <= '0;
      hw_reset_prev_q <= 1'b1;
    end else begin
      hw_reset_prev_q <= hw_reset_n;
      if (!hw_reset_n && hw_reset_prev_q) begin
        hw_busy_q <= 1'b1;
        rst_cnt_q <= busy_d ? CW'(READY_BUSY_CYCLES) : CW'(READY_IDLE_CYC);
      end else if (rst_cnt_q > 1) begin
        rst_cnt_q <= rst_cnt_q - 1'b1;
      end else begin
        rst_cnt_q <= '0;
        hw_busy_q <= 1'b0;
      end
    end
  end

  // Read permission after reset high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rh_cnt_q <= '0;
      read_allowed <= 1'b1;
    end else if (!hw_reset_n) begin
      rh_cnt_q <= CW'(RH_CYC);
      read_allowed <= 1'b0;
    end else if (rh_cnt_q > 1) begin
      rh_cnt_q <= rh_cnt_q - 1'b1;
    end else begin
      rh_cnt_q <= '0;
      read_allowed <= !hw_busy_q;
    end
  end

  // Open-drain pin: enable only to pull low, never drive high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      engine_start <= 1'b0;
      ready_busy_n_oe <= 1'b0;
      ready_busy_n_out <= 1'b0;
    end else begin
      busy <= busy_d;
      engine_start <= hw_reset_n && accept_new && !cmd.protect &&
                      ((state_q == ST_READ && (cmd.kind == CMD_PROGRAM ||
                        cmd.kind == CMD_CHIP_ERASE || cmd.kind == CMD_SECTOR_ERASE)) ||
                       (state_q == ST_SUSP && cmd.kind == CMD_PROGRAM));
      ready_busy_n_oe <= busy_d || hw_busy_q || !hw_reset_n;
      ready_busy_n_out <= 1'b0;
    end
  end

  // Assertions
  chk_prog_busy_pin: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_READ && accept_new && !cmd.protect && cmd.kind == CMD_PROGRAM && hw_reset_n)
    |=> ##1 ready_busy_n_oe)
    else $error("program did not pull ready busy low");

  chk_erase_busy_pin: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_READ && accept_new && !cmd.protect && hw_reset_n &&
     cmd.kind == CMD_SECTOR_ERASE) |=> state_q == ST_ERASE ##1 ready_busy_n_oe)
    else $error("erase did not pull ready busy low");

  chk_suspend_release: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_SUSP && !hw_busy_q && hw_reset_n) |=> !ready_busy_n_oe)
    else $error("suspend did not release ready busy");

  chk_never_drive_high: assert property (@(posedge clk_sys) disable iff (rst)
    ready_busy_n_oe |-> !ready_busy_n_out)
    else $error("ready busy driven high");

  chk_prog_inverted: assert property (@(posedge clk_sys) disable iff (rst)
    (read_strobe && poll_bank_hit && state_q == ST_PROG && hw_reset_n)
    |=> read_data[POLARITY_POS] == ~$past(last_data_q[POLARITY_POS]))
    else $error("polling bit not inverted");

  chk_erase_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (read_strobe && poll_bank_hit && state_q == ST_ERASE) |=> !read_data[POLARITY_POS])
    else $error("erase polling bit not zero");

  chk_busy_ignores: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_PROG && cmd_valid && !engine.done && !engine.limit && hw_reset_n)
    |=> state_q == ST_PROG)
    else $error("command accepted while busy");

  chk_limit_fail: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_ERASE && engine.limit && hw_reset_n &&
     !(cmd_valid && cmd.kind == CMD_SUSPEND)) |=> state_q == ST_FAIL)
    else $error("pulse limit did not fail");

  chk_idle_reads_array: assert property (@(posedge clk_sys) disable iff (rst)
    (read_strobe && state_q == ST_READ && guard_q == '0 && !settle_q)
    |=> read_data == $past(array_data))
    else $error("idle read not array data");

  // Steps after an erase is taken: erase state, then the pin pulled low
  sequence s_erase_then_low;
    state_q == ST_ERASE ##1 ready_busy_n_oe;
  endsequence

  // Steps after a suspend is taken: suspend state, then busy dropped
  sequence s_suspended;
    state_q == ST_SUSP ##1 !busy;
  endsequence

  chk_chip_busy_pin: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_READ && accept_new && !cmd.protect && hw_reset_n &&
     cmd.kind == CMD_CHIP_ERASE) |=> s_erase_then_low)
    else $error("chip erase did not pull ready busy low");

  chk_suspend_taken: assert property (@(posedge clk_sys) disable iff (rst)
    (state_q == ST_ERASE && cmd_valid && cmd.kind == CMD_SUSPEND && hw_reset_n)
    |=> s_suspended)
    else $error("erase suspend not taken");

  chk_reset_busy_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (!hw_reset_n && hw_reset_prev_q && busy_d && READY_BUSY_CYCLES > 8) |=> hw_busy_q [*8])
    else $error("busy not held through reset recovery");

  chk_fail_timeout_bit: assert property (@(posedge clk_sys) disable iff (rst)
    (read_strobe && poll_bank_hit && state_q == ST_FAIL && guard_q == '0)
    |=> read_data[TIMEOUT_POS])
    else $error("timeout bit not set after pulse limit");

  chk_settle_true_bit: assert property (@(posedge clk_sys) disable iff (rst)
    (read_strobe && poll_bank_hit && state_q == ST_READ && settle_q && guard_q == '0)
    |=> read_data[POLARITY_POS] == $past(array_data[POLARITY_POS]))
    else $error("settle read polarity bit not true");

  chk_settle_once: assert property (@(posedge clk_sys) disable iff (rst)
    (read_strobe && settle_q && !engine.done) |=> !settle_q)
    else $error("settle read repeated");

  chk_guard_poll: assert property (@(posedge clk_sys) disable iff (rst)
    (read_strobe && poll_bank_hit && state_q == ST_READ && guard_prog_q)
    |=> read_data[POLARITY_POS] == ~$past(last_data_q[POLARITY_POS]))
    else $error("protected program poll not inverted");

  chk_erase_toggles: assert property (@(posedge clk_sys) disable iff (rst)
    (read_strobe && (state_q == ST_ERASE || guard_erase_q)) |=> toggle_q != $past(toggle_q))
    else $error("toggle bit did not toggle");

  chk_reset_read_wait: assert property (@(posedge clk_sys) disable iff (rst)
    !hw_reset_n |=> !read_allowed)
    else $error("read allowed during hardware reset");

endmodule

// File: verification/flash_host_model.sv
// Host side model: frames commands and polls status reads
`timescale 1ns/1ps
module flash_host_model
  import flash_status_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Toward the status block
  output logic cmd_valid,
  output cmd_s cmd,
  output logic read_strobe,
  output logic poll_bank_hit,
  // From the status block
  input wire logic [15:0] read_data,
  input wire logic read_allowed
);
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    read_strobe = 1'b0;
    poll_bank_hit = 1'b0;
  end

  // One framed command; fields scrambled once the strobe is gone
  task automatic send(input cmd_e kind, input logic prot, input logic [15:0] d);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd = '{kind, prot, d};
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd = ~cmd;
  endtask

  // One read at the operated sector, once reads are allowed or after 200 cycles of waiting
  task automatic read_word(output logic [15:0] w);
    int n;
    n = 0;
    while (read_allowed !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    read_strobe = 1'b1;
    poll_bank_hit = 1'b1;
    @(negedge clk_sys);
    read_strobe = 1'b0;
    @(negedge clk_sys);
    w = read_data;
  endtask

  // Status may flip mid-read, so a second read confirms the array word
  task automatic settle_read(output logic [15:0] first, output logic [15:0] w);
    read_word(first);
    read_word(w);
  endtask
endmodule

// File: verification/flash_write_status_test.sv
// Self-checking bench for the write-status reporting block
`timescale 1ns/1ps
`define CHK(g, e) check_val(64'(g), 64'(e))
module flash_write_status_test;
  import flash_status_pkg::*;
  logic clk_sys;
  logic rst;
  logic cmd_valid;
  cmd_s cmd;
  engine_s engine;
  logic read_strobe;
  logic poll_bank_hit;
  logic [15:0] array_data;
  logic hw_reset_n;
  logic [15:0] read_data;
  logic busy;
  logic engine_start;
  logic ready_busy_n_oe;
  logic ready_busy_n_out;
  logic read_allowed;
  logic [15:0] w;
  logic [15:0] w0;
  int bad_count;
  int n_checks;
  int starts;
  // Open-drain pin with an external pull-up
  wire ry_pin = ready_busy_n_oe ? ready_busy_n_out : 1'b1;

  flash_write_status #(.WIDTH(16), .PROT_ERASE_CYCLES(20), .READY_BUSY_CYCLES(20))
    flash_write_status_inst (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .engine(engine), .read_strobe(read_strobe), .poll_bank_hit(poll_bank_hit),
    .array_data(array_data), .hw_reset_n(hw_reset_n), .read_data(read_data), .busy(busy),
    .engine_start(engine_start), .ready_busy_n_oe(ready_busy_n_oe),
    .ready_busy_n_out(ready_busy_n_out), .read_allowed(read_allowed));

  flash_host_model flash_host_model_inst (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd(cmd), .read_strobe(read_strobe), .poll_bank_hit(poll_bank_hit),
    .read_data(read_data), .read_allowed(read_allowed));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Count accepted operations
  always @(posedge clk_sys) begin
    if (engine_start === 1'b1) begin
      starts++;
    end
  end

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One-cycle completion report from the array engine
  task automatic eng(input logic done, input logic limit);
    @(negedge clk_sys);
    engine = '{done, limit};
    @(negedge clk_sys);
    engine = '0;
  endtask

  // Watchdog, well beyond the expected run
  initial begin
    #(20 * 5000);
    bad_count++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    engine = '0;
    array_data = 16'h0080;
    hw_reset_n = 1'b1;
    starts = 0;
    cycles(16);
    rst = 1'b0;
    // Idle: array data, pin floating
    flash_host_model_inst.read_word(w);
    `CHK(w, 16'h0080);
    `CHK(ry_pin, 1'b1);
    // Program, refused second program, completion
    flash_host_model_inst.send(CMD_PROGRAM, 1'b0, 16'h0080);
    cycles(2);
    `CHK({busy, ry_pin}, 2'b10);
    flash_host_model_inst.read_word(w);
    `CHK(w[7], 1'b0);
    flash_host_model_inst.send(CMD_PROGRAM, 1'b0, 16'h1234);
    cycles(2);
    `CHK(starts, 1);
    flash_host_model_inst.read_word(w);
    `CHK(w[7], 1'b0);
    eng(1'b1, 1'b0);
    cycles(2);
    `CHK({busy, ry_pin}, 2'b01);
    flash_host_model_inst.settle_read(w0, w);
    `CHK(w0[7], 1'b1);
    `CHK(w, 16'h0080);
    // Sector erase with suspend and resume
    array_data = 16'hffff;
    flash_host_model_inst.send(CMD_SECTOR_ERASE, 1'b0, 16'h0000);
    cycles(2);
    `CHK(ry_pin, 1'b0);
    flash_host_model_inst.read_word(w);
    `CHK(w[7], 1'b0);
    flash_host_model_inst.send(CMD_SUSPEND, 1'b0, 16'h0000);
    cycles(3);
    `CHK(ry_pin, 1'b1);
    flash_host_model_inst.read_word(w);
    `CHK(w[7], 1'b0);
    // Program inside the suspend: busy again, inverted poll, ready after done
    flash_host_model_inst.send(CMD_PROGRAM, 1'b0, 16'h0080);
    cycles(2);
    flash_host_model_inst.read_word(w);
    `CHK({w[7], busy, ry_pin}, 3'b010);
    eng(1'b1, 1'b0);
    cycles(2);
    `CHK({busy, ry_pin}, 2'b01);
    flash_host_model_inst.send(CMD_RESUME, 1'b0, 16'h0000);
    eng(1'b1, 1'b0);
    cycles(2);
    flash_host_model_inst.settle_read(w0, w);
    `CHK({w0[7], w}, {1'b1, 16'hffff});
    // Chip erase running into the pulse limit
    flash_host_model_inst.send(CMD_CHIP_ERASE, 1'b0, 16'h0000);
    cycles(2);
    `CHK(ry_pin, 1'b0);
    flash_host_model_inst.read_word(w);
    `CHK(w[7], 1'b0);
    eng(1'b0, 1'b1);
    flash_host_model_inst.read_word(w);
    `CHK(w[5], 1'b1);
    flash_host_model_inst.send(CMD_RESET, 1'b0, 16'h0000);
    cycles(2);
    flash_host_model_inst.settle_read(w0, w);
    `CHK(w, 16'hffff);
    // Protected program: short inverted poll, no busy, data kept
    array_data = 16'h0000;
    flash_host_model_inst.send(CMD_PROGRAM, 1'b1, 16'h0080);
    flash_host_model_inst.read_word(w);
    `CHK({w[7], ry_pin}, 2'b01);
    cycles(60);
    flash_host_model_inst.read_word(w);
    `CHK(w, 16'h0000);
    // Protected erase: toggle bit alternates, then array data
    flash_host_model_inst.send(CMD_SECTOR_ERASE, 1'b1, 16'h0000);
    flash_host_model_inst.read_word(w0);
    flash_host_model_inst.read_word(w);
    `CHK(w[6] ^ w0[6], 1'b1);
    cycles(30);
    flash_host_model_inst.read_word(w);
    `CHK(w, 16'h0000);
    // Hardware reset during a program holds the pin low
    flash_host_model_inst.send(CMD_PROGRAM, 1'b0, 16'h0001);
    cycles(3);
    hw_reset_n = 1'b0;
    cycles(5);
    hw_reset_n = 1'b1;
    cycles(1);
    `CHK({ry_pin, read_allowed}, 2'b00);
    cycles(40);
    `CHK({ry_pin, read_allowed}, 2'b11);
    // Hardware reset while idle
    hw_reset_n = 1'b0;
    cycles(3);
    hw_reset_n = 1'b1;
    cycles(1);
    `CHK(read_allowed, 1'b0);
    cycles(40);
    `CHK({ry_pin, read_allowed}, 2'b11);
    report_and_stop();
  end
endmodule
